//--- dv/scl_chk_sva.sv
// Port checker for the configuration loader
`timescale 1ns/1ps
module scl_chk
    import scl_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic tck,
    input wire logic serial_config_clock,
    input wire logic config_fault_n_in,
    input wire logic cfg_bit_vld,
    input wire logic chain_enable_out_n,
    input wire logic config_done_oe_n,
    input wire logic tdo_out,
    input wire logic tdo_oe_n,
    input wire logic user_io_hiz,
    input wire logic decompress_en,
    input wire logic security_en,
    input wire logic init_active,
    input wire logic user_mode,
    input wire logic jtag_cfg_active
);
    // ------------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_jtag_hiz: assert property (jtag_cfg_active |-> user_io_hiz)
        else $error("user io driven in jtag load");
    a_user_io: assert property (user_io_hiz == !user_mode)
        else $error("user io state wrong");
    a_jtag_opts: assert property (jtag_cfg_active |->
        !decompress_en && !security_en) else $error("options on in jtag");
    a_bit_pulse: assert property (cfg_bit_vld |=> !cfg_bit_vld)
        else $error("bit strobe too long");
    a_ser_edge: assert property (cfg_bit_vld && !jtag_cfg_active
        |-> serial_config_clock) else $error("serial bit off clock");
    a_tck_rise: assert property (cfg_bit_vld && jtag_cfg_active
        |-> tck) else $error("jtag bit not on tck high");
    // Output moves must land while the test clock is low
    a_tdo_fall: assert property ($changed(tdo_out)
        || $changed(tdo_oe_n) |-> !tck) else $error("tdo moved on tck high");
    a_done_rel: assert property ($fell(chain_enable_out_n)
        |-> ##[0:2] config_done_oe_n) else $error("done not released");
    a_init_hold: assert property ($rose(init_active)
        |-> init_active[*8]) else $error("init cut short");
    a_user_done: assert property ($rose(user_mode)
        |-> config_done_oe_n) else $error("user mode with done held");
    a_fault_stop: assert property ((!config_fault_n_in)[*6]
        |-> !cfg_bit_vld) else $error("bit taken during fault");

    c_loaded: cover property ($fell(chain_enable_out_n));
    c_user: cover property ($rose(user_mode));
    c_jtag: cover property ($rose(jtag_cfg_active));
endmodule : scl_chk

bind scl_config_loader scl_chk scl_chk_inst (
    .mclk, .rstn, .tck, .serial_config_clock, .config_fault_n_in,
    .cfg_bit_vld, .chain_enable_out_n, .config_done_oe_n, .tdo_out,
    .tdo_oe_n, .user_io_hiz, .decompress_en, .security_en,
    .init_active, .user_mode, .jtag_cfg_active
);

//--- dv/scl_host.sv
// Host model that clocks a bitstream into the serial pins
`timescale 1ns/1ps
module scl_host (
    input  wire logic        run,
    input  wire logic [63:0] pat,
    output logic             sclk,
    output logic             sdat
);
    int n;
    // ------------------------------------------------------------------
    // Bit clocking
    // ------------------------------------------------------------------
    // Clock stands low between loads; data idles at its pull-up level
    initial begin
        n = 0;
        sclk = 1'b0;
        sdat = 1'b1;
        forever begin
            wait (run);
            sdat = (n < 64) ? pat[n] : ~sdat;
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
            if (run) begin
                n++;
            end else begin
                // A restart always begins again at the first bit
                n = 0;
                sdat = 1'b1;
            end
        end
    end
endmodule : scl_host

//--- dv/tb.sv
// Self-checking bench for the configuration loader
`timescale 1ns/1ps
module tb
    import scl_pkg::*;
;
    logic        mclk, rstn, run, tck, tms, tdi, tdo_s, oe_s, ce_in_n;
    logic        cfg_error, compress_opt, security_opt, fault_ext, done_ext;
    logic        reconfig_request_n, serial_config_clock, serial_config_data;
    logic        cfg_bit, cfg_bit_vld, chain_enable_out_n, config_fault_n_out;
    logic        config_fault_oe_n, config_done_out, config_done_oe_n;
    logic        tdo_out, tdo_oe_n, user_io_hiz, decompress_en, security_en;
    logic        init_active, user_mode, jtag_cfg_active;
    logic [63:0] pat;
    wire logic   config_fault_n_in, config_done_in;
    int          mismatches, tests_run, nvld, k, i;
    // Shared open-drain lines sit low while any party pulls them
    assign config_fault_n_in = fault_ext
        & (config_fault_oe_n | config_fault_n_out);
    assign config_done_in = done_ext & (config_done_oe_n | config_done_out);
    scl_host scl_host_inst (.run, .pat, .sclk(serial_config_clock),
        .sdat(serial_config_data));
    scl_config_loader scl_config_loader_inst (
        .mclk, .rstn, .ce(1'b1), .serial_config_clock, .serial_config_data,
        .chip_enable_in_n(ce_in_n), .reconfig_request_n, .config_fault_n_in,
        .config_done_in, .tck, .tms, .tdi, .cfg_error, .compress_opt,
        .security_opt, .cfg_bit, .cfg_bit_vld, .chain_enable_out_n,
        .config_fault_n_out, .config_fault_oe_n, .config_done_out,
        .config_done_oe_n, .tdo_out, .tdo_oe_n, .user_io_hiz,
        .decompress_en, .security_en, .init_active, .user_mode,
        .jtag_cfg_active
    );
    // ------------------------------------------------------------------
    // Clock, checks and pin tasks
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task end_of_test;
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    task automatic wt(ref logic s, input logic v);
        for (int j = 0; j < 20000 && s !== v; j++) @(negedge mclk);
        if (s !== v) begin
            mismatches++;
            end_of_test();
        end
    endtask : wt
    // Test clock edges are kept off the system clock edges on purpose
    task jclk(input logic m, input logic d);
        tms = m;
        tdi = d;
        #62.5 tck = 1'b1;
        tdo_s = tdo_out;
        oe_s = tdo_oe_n;
        #62.5 tck = 1'b0;
    endtask : jclk
    task jseq(input logic [15:0] m, input logic [15:0] d, input int n);
        for (int j = 0; j < n; j++) jclk(m[j], d[j]);
    endtask : jseq
    task restart;
        @(negedge mclk);
        run = 1'b0;
        reconfig_request_n = 1'b0;
        repeat (20) @(negedge mclk);
        reconfig_request_n = 1'b1;
        nvld = 0;
        repeat (10) @(negedge mclk);
        #1 run = 1'b1;
    endtask : restart
    // Every accepted bit must be the next one of the stream
    always @(negedge mclk) begin
        if (cfg_bit_vld === 1'b1) begin
            chk(cfg_bit, pat[nvld]);
            nvld++;
        end
    end
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        {rstn, run, cfg_error, compress_opt, security_opt} = 5'h00;
        mismatches = 0;
        tests_run = 0;
        nvld = 0;
        reconfig_request_n = 1'b1;
        fault_ext = 1'b1;
        done_ext = 1'b0;
        ce_in_n = 1'b0;
        pat = 64'hC3A5_0F96_5A3C_E718;
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        repeat (5) @(negedge mclk);
        rstn = 1'b1;
        repeat (4) @(negedge mclk);
        chk(tdo_oe_n, 1'b1);
        chk(user_io_hiz, 1'b1);
        #1 run = 1'b1;
        wt(chain_enable_out_n, 1'b0);
        chk(nvld[15:0], CFG_LEN);
        repeat (40) @(negedge mclk);
        chk(config_done_oe_n, 1'b1);
        chk(init_active, 1'b0);
        done_ext = 1'b1;
        wt(init_active, 1'b1);
        #1 run = 1'b0;
        wt(user_mode, 1'b1);
        chk(user_io_hiz, 1'b0);
        for (k = 0; k < 2; k++) begin
            restart();
            repeat (150) @(negedge mclk);
            fault_ext = k[0];
            cfg_error = k[0];
            repeat (20) @(negedge mclk);
            i = nvld;
            repeat (300) @(negedge mclk);
            chk(nvld[15:0], i[15:0]);
            chk(config_fault_oe_n, !k[0]);
            fault_ext = 1'b1;
            cfg_error = 1'b0;
            repeat (300) @(negedge mclk);
            chk(nvld[15:0], i[15:0]);
            chk(user_mode, 1'b0);
        end
        // Not enabled by the chain: serial clocks must be ignored
        ce_in_n = 1'b1;
        restart();
        repeat (100) @(negedge mclk);
        chk(nvld[15:0], CNT_ZERO);
        reconfig_request_n = 1'b0;
        ce_in_n = 1'b0;
        compress_opt = 1'b1;
        security_opt = 1'b1;
        restart();
        repeat (100) @(negedge mclk);
        chk(decompress_en, 1'b1);
        chk(security_en, 1'b1);
        #1 jseq(16'h60DF, 16'hCBFF, 16);
        jseq(16'h0001, 16'hFFFF, 3);
        #50 nvld = 0;
        chk(jtag_cfg_active, 1'b1);
        chk(user_io_hiz, 1'b1);
        chk(decompress_en, 1'b0);
        chk(security_en, 1'b0);
        for (k = 0; k < 64; k++) begin
            jclk(k == 63, pat[k]);
            if (k > 0) begin
                chk(tdo_s, pat[k-1]);
                chk(oe_s, 1'b0);
            end
        end
        chk(nvld[15:0], CFG_LEN);
        jseq(16'h0001, 16'hFFFF, 2);
        for (k = 0; k < 1094; k++) jclk(1'b0, 1'b1);
        tms = 1'b1;
        wt(user_mode, 1'b1);
        end_of_test();
    end
endmodule : tb

//--- logic/scl_config_loader.sv
// Serial and boundary-scan configuration loader, top level
`timescale 1ns/1ps
module scl_config_loader
    import scl_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic ce,
    input  wire logic serial_config_clock,
    input  wire logic serial_config_data,
    input  wire logic chip_enable_in_n,
    input  wire logic reconfig_request_n,
    input  wire logic config_fault_n_in,
    input  wire logic config_done_in,
    input  wire logic tck,
    input  wire logic tms,
    input  wire logic tdi,
    input  wire logic cfg_error,
    input  wire logic compress_opt,
    input  wire logic security_opt,
    output logic      cfg_bit,
    output logic      cfg_bit_vld,
    output logic      chain_enable_out_n,
    output logic      config_fault_n_out,
    output logic      config_fault_oe_n,
    output logic      config_done_out,
    output logic      config_done_oe_n,
    output logic      tdo_out,
    output logic      tdo_oe_n,
    output logic      user_io_hiz,
    output logic      decompress_en,
    output logic      security_en,
    output logic      init_active,
    output logic      user_mode,
    output logic      jtag_cfg_active
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    scl_ser_pins_t  ser_pin, ser_lvl, ser_rise, ser_fall;
    scl_jtag_pins_t jt_pin,  jt_lvl,  jt_rise,  jt_fall;

    // A zero reset would fake a reconfiguration request on the shared line
    localparam scl_ser_pins_t SER_IDLE = '{clk: 1'b0, data: 1'b1, ce_n: 1'b1,
                                           reconfig_n: 1'b1, fault_n: 1'b1,
                                           done: 1'b0};

    assign ser_pin = '{clk: serial_config_clock, data: serial_config_data,
                       ce_n: chip_enable_in_n, reconfig_n: reconfig_request_n,
                       fault_n: config_fault_n_in, done: config_done_in};
    assign jt_pin  = '{tck: tck, tms: tms, tdi: tdi};

    scl_sync #(.W($bits(scl_ser_pins_t)), .RST(SER_IDLE)) u_ser_sync (
        .mclk   (mclk),
        .rstn   (rstn),
        .ce     (ce),
        .pin_in (ser_pin),
        .level  (ser_lvl),
        .rise   (ser_rise),
        .fall   (ser_fall)
    );

    scl_sync #(.W($bits(scl_jtag_pins_t))) u_jt_sync (
        .mclk   (mclk),
        .rstn   (rstn),
        .ce     (ce),
        .pin_in (jt_pin),
        .level  (jt_lvl),
        .rise   (jt_rise),
        .fall   (jt_fall)
    );

    // ------------------------------------------------------------------
    // Test access port
    // ------------------------------------------------------------------
    scl_tap_t        tap_state;
    logic [IR_W-1:0] tap_ir;
    logic            jt_bit_vld;
    logic            jt_bit;
    logic            jt_start;

    scl_tap u_tap (
        .mclk        (mclk),
        .rstn        (rstn),
        .ce          (ce),
        .tck_rise    (jt_rise.tck),
        .tck_fall    (jt_fall.tck),
        .tms         (jt_lvl.tms),
        .tdi         (jt_lvl.tdi),
        .state       (tap_state),
        .ir          (tap_ir),
        .cfg_bit_vld (jt_bit_vld),
        .cfg_bit     (jt_bit),
        .tdo_ff      (tdo_out),
        .tdo_oe_n_ff (tdo_oe_n)
    );

    // Loading starts once the load instruction is live and the DR is shifted
    assign jt_start = (tap_ir == IR_CFG_LOAD) && (tap_state == SCL_SHDR);

    // ------------------------------------------------------------------
    // Configuration sequencer
    // ------------------------------------------------------------------
    scl_cfg_t    st_ff,    nxt_st;
    logic [15:0] bit_ff,   nxt_bit;
    logic [15:0] cnt_ff,   nxt_cnt;
    logic        jdone_ff, nxt_jdone;
    logic        err_ff,   nxt_err;
    logic        nxt_cfg_bit;
    logic        nxt_cfg_vld;
    logic        nxt_ceo_n;
    logic        nxt_fault_oe_n;
    logic        nxt_done_oe_n;
    logic        nxt_hiz;
    logic        nxt_dec;
    logic        nxt_sec;
    logic        nxt_init;
    logic        nxt_user;
    logic        nxt_jact;
    logic        ser_go;

    // A fault on the shared line, ours or a neighbour's, halts this device
    assign ser_go = ser_lvl.reconfig_n && ser_lvl.fault_n && !cfg_error;

    always_comb begin
        nxt_st      = st_ff;
        nxt_bit     = bit_ff;
        nxt_cnt     = cnt_ff;
        nxt_jdone   = jdone_ff;
        nxt_err     = err_ff;
        nxt_cfg_bit = cfg_bit;
        nxt_cfg_vld = 1'b0;
        case (st_ff)
            SCL_IDLE: begin
                nxt_bit = CNT_ZERO;
                nxt_cnt = CNT_ZERO;
                nxt_err = 1'b0;
                if (ser_go && !ser_lvl.ce_n) begin
                    nxt_st = SCL_LOAD;
                end
            end
            SCL_LOAD: begin
                if (ser_rise.clk) begin
                    nxt_cfg_bit = ser_lvl.data;
                    nxt_cfg_vld = 1'b1;
                    nxt_bit     = scl_inc(bit_ff);
                    if (scl_inc(bit_ff) == CFG_LEN) begin
                        nxt_st  = SCL_WDONE;
                        nxt_cnt = CNT_ZERO;
                    end
                end
            end
            SCL_WDONE: begin
                // Shared done only rises when every device has released it
                if (ser_lvl.done && ser_fall.clk) begin
                    nxt_cnt = scl_inc(cnt_ff);
                    if (scl_inc(cnt_ff) == DONE_FALL_EDGES) begin
                        nxt_st  = SCL_INIT;
                        nxt_cnt = CNT_ZERO;
                    end
                end
            end
            SCL_INIT: begin
                // Internal count only; the user startup clock is never used
                nxt_cnt = scl_inc(cnt_ff);
                if (scl_inc(cnt_ff) == INIT_CYCLES) begin
                    nxt_st = SCL_USER;
                end
            end
            SCL_USER: begin
                nxt_cnt = CNT_ZERO;
            end
            SCL_FAULT: begin
                // No automatic retry; only a reconfiguration request or a boundary-scan load leaves
                nxt_bit = CNT_ZERO;
            end
            SCL_JTAG: begin
                if (!jdone_ff && jt_bit_vld) begin
                    nxt_cfg_bit = jt_bit;
                    nxt_cfg_vld = 1'b1;
                    nxt_bit     = scl_inc(bit_ff);
                    if (scl_inc(bit_ff) == CFG_LEN) begin
                        nxt_jdone = 1'b1;
                        nxt_cnt   = CNT_ZERO;
                    end
                end else if (jdone_ff && jt_rise.tck) begin
                    nxt_cnt = scl_inc(cnt_ff);
                    if (scl_inc(cnt_ff) == JTAG_INIT_TCK) begin
                        nxt_st = SCL_USER;
                    end
                end
            end
            default: begin
                nxt_st = SCL_IDLE;
            end
        endcase
        // Serial loading and init stop on any fault or request
        if (st_ff == SCL_LOAD || st_ff == SCL_WDONE || st_ff == SCL_INIT) begin
            if (!ser_lvl.reconfig_n) begin
                nxt_st = SCL_IDLE;
            end else if (!ser_go) begin
                nxt_st  = SCL_FAULT;
                nxt_err = cfg_error;
            end
        end
        if (st_ff == SCL_FAULT || st_ff == SCL_USER) begin
            if (!ser_lvl.reconfig_n) begin
                nxt_st = SCL_IDLE;
            end
        end
        // Boundary-scan loading wins over any serial activity
        if (jt_start && st_ff != SCL_JTAG) begin
            nxt_st      = SCL_JTAG;
            nxt_bit     = CNT_ZERO;
            nxt_cnt     = CNT_ZERO;
            nxt_jdone   = 1'b0;
            nxt_cfg_vld = 1'b0;
        end
        if (st_ff == SCL_JTAG && tap_state == SCL_TLR && !jdone_ff) begin
            nxt_st = SCL_IDLE;
        end
    end

    always_comb begin
        nxt_ceo_n      = !(st_ff == SCL_WDONE || st_ff == SCL_INIT ||
                           st_ff == SCL_USER);
        nxt_fault_oe_n = !((st_ff == SCL_FAULT && err_ff) ||
                           !ser_lvl.reconfig_n);
        nxt_done_oe_n  = !(st_ff == SCL_IDLE || st_ff == SCL_LOAD ||
                           st_ff == SCL_FAULT ||
                           (st_ff == SCL_JTAG && !jdone_ff));
        nxt_hiz        = (st_ff != SCL_USER);
        nxt_jact       = (st_ff == SCL_JTAG);
        nxt_dec        = compress_opt && (st_ff != SCL_JTAG);
        nxt_sec        = security_opt && (st_ff != SCL_JTAG);
        nxt_init       = (st_ff == SCL_INIT) ||
                         (st_ff == SCL_JTAG && jdone_ff);
        nxt_user       = (st_ff == SCL_USER);
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_ff              <= SCL_IDLE;
            bit_ff             <= CNT_ZERO;
            cnt_ff             <= CNT_ZERO;
            jdone_ff           <= 1'b0;
            err_ff             <= 1'b0;
            cfg_bit            <= 1'b0;
            cfg_bit_vld        <= 1'b0;
            chain_enable_out_n <= 1'b1;
            config_fault_n_out <= 1'b0;
            config_fault_oe_n  <= 1'b1;
            config_done_out    <= 1'b0;
            config_done_oe_n   <= 1'b0;
            user_io_hiz        <= 1'b1;
            decompress_en      <= 1'b0;
            security_en        <= 1'b0;
            init_active        <= 1'b0;
            user_mode          <= 1'b0;
            jtag_cfg_active    <= 1'b0;
        end else if (ce) begin
            st_ff              <= nxt_st;
            bit_ff             <= nxt_bit;
            cnt_ff             <= nxt_cnt;
            jdone_ff           <= nxt_jdone;
            err_ff             <= nxt_err;
            cfg_bit            <= nxt_cfg_bit;
            cfg_bit_vld        <= nxt_cfg_vld;
            chain_enable_out_n <= nxt_ceo_n;
            config_fault_n_out <= 1'b0;
            config_fault_oe_n  <= nxt_fault_oe_n;
            config_done_out    <= 1'b0;
            config_done_oe_n   <= nxt_done_oe_n;
            user_io_hiz        <= nxt_hiz;
            decompress_en      <= nxt_dec;
            security_en        <= nxt_sec;
            init_active        <= nxt_init;
            user_mode          <= nxt_user;
            jtag_cfg_active    <= nxt_jact;
        end
    end

endmodule : scl_config_loader

//--- logic/scl_pkg.sv
// Package of constants, states and pin carriers for the configuration loader
package scl_pkg;

    // ------------------------------------------------------------------
    // Sizes and counts
    // ------------------------------------------------------------------
    localparam int          CNT_W           = 16;
    localparam int          IR_W            = 4;
    localparam logic [15:0] CFG_LEN         = 16'h0040;
    localparam logic [15:0] DONE_FALL_EDGES = 16'h0002;
    localparam logic [15:0] JTAG_INIT_TCK   = 16'h0446;
    localparam logic [15:0] INIT_CYCLES     = 16'h0010;
    localparam logic [15:0] CNT_ZERO        = 16'h0000;

    // ------------------------------------------------------------------
    // Instructions
    // ------------------------------------------------------------------
    localparam logic [3:0]  IR_BYPASS       = 4'hF;
    localparam logic [3:0]  IR_CFG_LOAD     = 4'h2;
    localparam logic [3:0]  IR_CAPTURE      = 4'h1;

    typedef enum logic [3:0] {
        SCL_TLR   = 4'b0000,
        SCL_RTI   = 4'b0001,
        SCL_SELDR = 4'b0010,
        SCL_CAPDR = 4'b0011,
        SCL_SHDR  = 4'b0100,
        SCL_EX1DR = 4'b0101,
        SCL_PSDR  = 4'b0110,
        SCL_EX2DR = 4'b0111,
        SCL_UPDR  = 4'b1000,
        SCL_SELIR = 4'b1001,
        SCL_CAPIR = 4'b1010,
        SCL_SHIR  = 4'b1011,
        SCL_EX1IR = 4'b1100,
        SCL_PSIR  = 4'b1101,
        SCL_EX2IR = 4'b1110,
        SCL_UPIR  = 4'b1111
    } scl_tap_t;

    typedef enum logic [2:0] {
        SCL_IDLE  = 3'b000,
        SCL_LOAD  = 3'b001,
        SCL_WDONE = 3'b010,
        SCL_INIT  = 3'b011,
        SCL_USER  = 3'b100,
        SCL_FAULT = 3'b101,
        SCL_JTAG  = 3'b110
    } scl_cfg_t;

    // ------------------------------------------------------------------
    // Pin carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } scl_jtag_pins_t;

    typedef struct packed {
        logic clk;
        logic data;
        logic ce_n;
        logic reconfig_n;
        logic fault_n;
        logic done;
    } scl_ser_pins_t;

    function automatic logic [15:0] scl_inc(input logic [15:0] v);
        scl_inc = v + 16'h0001;
    endfunction : scl_inc

endpackage : scl_pkg

//--- logic/scl_sync.sv
// Two-stage pin synchroniser with edge pulses taken after the second stage
`timescale 1ns/1ps
module scl_sync
    import scl_pkg::*;
#(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         mclk,
    input  wire logic         rstn,
    input  wire logic         ce,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] nxt_s1;
    logic [W-1:0] nxt_s2;
    logic [W-1:0] nxt_s3;

    always_comb begin
        nxt_s1 = pin_in;
        nxt_s2 = s1_ff;
        nxt_s3 = s2_ff;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            // Reset to the pin's idle level so no false edge follows reset
            s1_ff <= RST;
            s2_ff <= RST;
            s3_ff <= RST;
        end else if (ce) begin
            s1_ff <= nxt_s1;
            s2_ff <= nxt_s2;
            s3_ff <= nxt_s3;
        end
    end

    // Edges compare stage two with stage three, never stage one
    assign level = s2_ff;
    assign rise  = s2_ff & ~s3_ff;
    assign fall  = ~s2_ff & s3_ff;

endmodule : scl_sync

//--- logic/scl_tap.sv
// Test access controller, instruction register and one-bit data path
`timescale 1ns/1ps
module scl_tap
    import scl_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      rstn,
    input  wire logic      ce,
    input  wire logic      tck_rise,
    input  wire logic      tck_fall,
    input  wire logic      tms,
    input  wire logic      tdi,
    output scl_tap_t       state,
    output logic [IR_W-1:0] ir,
    output logic           cfg_bit_vld,
    output logic           cfg_bit,
    output logic           tdo_ff,
    output logic           tdo_oe_n_ff
);
    scl_tap_t        st_ff,   nxt_st;
    logic            tms_ff,  nxt_tms;
    logic [IR_W-1:0] ir_ff,   nxt_ir;
    logic [IR_W-1:0] irsh_ff, nxt_irsh;
    logic            dr_ff,   nxt_dr;
    logic            nxt_tdo;
    logic            nxt_oe_n;

    function automatic scl_tap_t tap_next(input scl_tap_t s, input logic m);
        case (s)
            SCL_TLR:   tap_next = m ? SCL_TLR   : SCL_RTI;
            SCL_RTI:   tap_next = m ? SCL_SELDR : SCL_RTI;
            SCL_SELDR: tap_next = m ? SCL_SELIR : SCL_CAPDR;
            SCL_CAPDR: tap_next = m ? SCL_EX1DR : SCL_SHDR;
            SCL_SHDR:  tap_next = m ? SCL_EX1DR : SCL_SHDR;
            SCL_EX1DR: tap_next = m ? SCL_UPDR  : SCL_PSDR;
            SCL_PSDR:  tap_next = m ? SCL_EX2DR : SCL_PSDR;
            SCL_EX2DR: tap_next = m ? SCL_UPDR  : SCL_SHDR;
            SCL_UPDR:  tap_next = m ? SCL_SELDR : SCL_RTI;
            SCL_SELIR: tap_next = m ? SCL_TLR   : SCL_CAPIR;
            SCL_CAPIR: tap_next = m ? SCL_EX1IR : SCL_SHIR;
            SCL_SHIR:  tap_next = m ? SCL_EX1IR : SCL_SHIR;
            SCL_EX1IR: tap_next = m ? SCL_UPIR  : SCL_PSIR;
            SCL_PSIR:  tap_next = m ? SCL_EX2IR : SCL_PSIR;
            SCL_EX2IR: tap_next = m ? SCL_UPIR  : SCL_SHIR;
            SCL_UPIR:  tap_next = m ? SCL_SELDR : SCL_RTI;
            default:   tap_next = SCL_TLR;
        endcase
    endfunction : tap_next

    always_comb begin
        nxt_st   = st_ff;
        nxt_tms  = tms_ff;
        nxt_ir   = ir_ff;
        nxt_irsh = irsh_ff;
        nxt_dr   = dr_ff;
        nxt_tdo  = tdo_ff;
        nxt_oe_n = tdo_oe_n_ff;
        if (tck_rise) begin
            nxt_tms = tms;
            if (st_ff == SCL_SHIR) begin
                nxt_irsh = {tdi, irsh_ff[IR_W-1:1]};
            end
            if (st_ff == SCL_SHDR) begin
                nxt_dr = tdi;
            end
            if (st_ff == SCL_CAPIR) begin
                nxt_irsh = IR_CAPTURE;
            end
        end
        if (tck_fall) begin
            nxt_st = tap_next(st_ff, tms_ff);
            if (st_ff == SCL_UPIR) begin
                nxt_ir = irsh_ff;
            end
            if (st_ff == SCL_TLR) begin
                nxt_ir = IR_BYPASS;
            end
            // Output follows the state just shifted; one cycle behind input
            nxt_oe_n = !(st_ff == SCL_SHIR || st_ff == SCL_SHDR);
            nxt_tdo  = (st_ff == SCL_SHIR) ? irsh_ff[0] : dr_ff;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_ff       <= SCL_TLR;
            tms_ff      <= 1'b1;
            ir_ff       <= IR_BYPASS;
            irsh_ff     <= IR_BYPASS;
            dr_ff       <= 1'b0;
            tdo_ff      <= 1'b0;
            tdo_oe_n_ff <= 1'b1;
        end else if (ce) begin
            st_ff       <= nxt_st;
            tms_ff      <= nxt_tms;
            ir_ff       <= nxt_ir;
            irsh_ff     <= nxt_irsh;
            dr_ff       <= nxt_dr;
            tdo_ff      <= nxt_tdo;
            tdo_oe_n_ff <= nxt_oe_n;
        end
    end

    assign state       = st_ff;
    assign ir          = ir_ff;
    assign cfg_bit_vld = tck_rise && (st_ff == SCL_SHDR) &&
                         (ir_ff == IR_CFG_LOAD);
    assign cfg_bit     = tdi;

endmodule : scl_tap
